// File: core/smbrs_fifo.sv
// Write-data FIFO between the bus engine and the memories
`timescale 1ns/100ps
module smbrs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;

    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk_sys)
    begin
        if (in_valid && !full)
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (out_ready && !empty)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

// File: core/smbrs_slave.sv
// Two-wire slave port reaching configuration RAM and page-erased EEPROM
`timescale 1ns/100ps
`include "smbrs_cfg.svh"
module smbrs_slave #(
    parameter int ERASE_CYCLES = `SMBRS_ERASE_TIME_MS * (`SMBRS_CLK_HZ / `SMBRS_HZ_PER_KHZ),
    parameter int FIFO_DEPTH = `SMBRS_FIFO_DEPTH
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Two-wire bus, SDA open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Address straps
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    // Status
    output logic erase_busy
);
    localparam int WR_W = $bits(smbrs_pkg::smbrs_wr_t);

    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [6:0] own_addr;

    smbrs_pkg::smbrs_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic rw_ff;
    logic [1:0] byte_idx_ff;
    logic [7:0] cmd_ff;
    logic [15:0] ptr_ff;
    logic master_ack_ff;
    logic sda_oe_ff;
    logic sda_out_ff;
    logic [7:0] cfg_ff;

    logic busy_ff;
    logic [31:0] erase_cnt_ff;
    logic [4:0] erase_page_ff;

    logic [7:0] ram_mem [0:`SMBRS_RAM_WORDS-1];
    logic [7:0] eep_mem [0:`SMBRS_EEP_WORDS-1];

    logic byte_done;
    logic addr_match;
    logic rx_accept;
    logic push_valid;
    logic push_ready;
    smbrs_pkg::smbrs_wr_t push_data;
    logic ptr_load;
    logic [15:0] nxt_ptr;
    logic erase_start;
    logic drain_valid;
    logic drain_ready;
    smbrs_pkg::smbrs_wr_t drain_data;
    logic [7:0] rd_byte;

    function automatic logic is_ram(input logic [15:0] a);
        is_ram = (a[15:8] == 8'h00) && (a[7:0] <= `SMBRS_RAM_LAST);
    endfunction

    function automatic logic is_eep_hi(input logic [7:0] b);
        is_eep_hi = (b >= `SMBRS_EEP_HI_FIRST) && (b <= `SMBRS_EEP_HI_LAST);
    endfunction

    smbrs_sync #(
        .W(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d_in({scl_i, sda_i, addr_select_hi_pin, addr_select_lo_pin}),
        .q_out(pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign own_addr = {`SMBRS_ADDR_UPPER, pins_s[1], pins_s[0]};

    // Bus condition detection on synchronised levels
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end
        else
        begin
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
        end
    end

    assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
    assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
    assign scl_rise = scl_s && !scl_prev_ff;
    assign scl_fall = !scl_s && scl_prev_ff;
    assign byte_done = scl_fall && (bit_cnt_ff == `SMBRS_BITS_PER_BYTE);
    assign addr_match = (shift_ff[7:1] == own_addr) && !busy_ff;

    // Memory read for transmit, at the held pointer
    always_comb
    begin
        rd_byte = `SMBRS_READ_NONE;
        if (is_ram(ptr_ff))
        begin
            if (ptr_ff[7:0] == `SMBRS_CFG_ADDR)
                rd_byte = cfg_ff;
            else
                rd_byte = ram_mem[ptr_ff[7:0]];
        end
        else if (is_eep_hi(ptr_ff[15:8]))
            rd_byte = eep_mem[ptr_ff[9:0]];
    end

    // Decode of each received write byte
    always_comb
    begin
        rx_accept = 1'b1;
        push_valid = 1'b0;
        push_data = '0;
        ptr_load = 1'b0;
        nxt_ptr = ptr_ff;
        erase_start = 1'b0;
        case (byte_idx_ff)
            2'd0:
            begin
                if (is_ram({8'h00, shift_ff}))
                begin
                    ptr_load = 1'b1;
                    nxt_ptr = {8'h00, shift_ff};
                end
                if ((shift_ff == `SMBRS_CMD_ERASE) && cfg_ff[`SMBRS_CFG_ERASE_EN_BIT] && !busy_ff)
                    erase_start = 1'b1;
            end
            2'd1:
            begin
                if (is_ram({8'h00, cmd_ff}))
                begin
                    push_valid = 1'b1;
                    push_data = '{to_eep: 1'b0, addr: ptr_ff, data: shift_ff};
                    rx_accept = push_ready;
                end
                else if (is_eep_hi(cmd_ff))
                begin
                    ptr_load = 1'b1;
                    nxt_ptr = {cmd_ff, shift_ff};
                end
            end
            2'd2:
            begin
                if (is_eep_hi(cmd_ff))
                begin
                    push_valid = 1'b1;
                    push_data = '{to_eep: 1'b1, addr: ptr_ff, data: shift_ff};
                    rx_accept = push_ready;
                end
                else
                    rx_accept = 1'b0;
            end
            default:
                rx_accept = 1'b0;
        endcase
    end

    // Bit and byte sequencing
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= smbrs_pkg::ST_IDLE;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            tx_ff <= '0;
            rw_ff <= 1'b0;
            byte_idx_ff <= '0;
            cmd_ff <= '0;
            master_ack_ff <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff <= smbrs_pkg::ST_ADDR;
            bit_cnt_ff <= '0;
            byte_idx_ff <= '0;
        end
        else if (stop_det)
            state_ff <= smbrs_pkg::ST_IDLE;
        else
        begin
            case (state_ff)
                smbrs_pkg::ST_ADDR, smbrs_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (byte_done && state_ff == smbrs_pkg::ST_ADDR)
                    begin
                        if (addr_match)
                        begin
                            state_ff <= smbrs_pkg::ST_ADDR_ACK;
                            rw_ff <= shift_ff[0];
                        end
                        else
                            state_ff <= smbrs_pkg::ST_IGNORE;
                    end
                    else if (byte_done)
                    begin
                        state_ff <= smbrs_pkg::ST_RX_ACK;
                        if (byte_idx_ff == 2'd0)
                            cmd_ff <= shift_ff;
                        if (byte_idx_ff != 2'd3)
                            byte_idx_ff <= byte_idx_ff + 2'd1;
                    end
                end
                smbrs_pkg::ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_ff <= '0;
                        if (rw_ff)
                        begin
                            state_ff <= smbrs_pkg::ST_TX;
                            tx_ff <= rd_byte;
                        end
                        else
                            state_ff <= smbrs_pkg::ST_RX;
                    end
                end
                smbrs_pkg::ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_ff <= '0;
                        state_ff <= (sda_oe_ff) ? smbrs_pkg::ST_RX : smbrs_pkg::ST_IGNORE;
                    end
                end
                smbrs_pkg::ST_TX:
                begin
                    if (scl_rise)
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    else if (byte_done)
                        state_ff <= smbrs_pkg::ST_TX_ACK;
                    else if (scl_fall)
                        tx_ff <= {tx_ff[6:0], 1'b0};
                end
                smbrs_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                        master_ack_ff <= !sda_s;
                    else if (scl_fall)
                    begin
                        bit_cnt_ff <= '0;
                        if (master_ack_ff)
                        begin
                            state_ff <= smbrs_pkg::ST_TX;
                            tx_ff <= rd_byte;
                        end
                        else
                            state_ff <= smbrs_pkg::ST_IGNORE;
                    end
                end
                smbrs_pkg::ST_IGNORE:
                    bit_cnt_ff <= '0;
                default:
                    state_ff <= smbrs_pkg::ST_IDLE;
            endcase
        end
    end

    // SDA drive, changed just after SCL falls, released on start or stop
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end
        else if (start_det || stop_det)
            sda_oe_ff <= 1'b0;
        else if (scl_fall)
        begin
            case (state_ff)
                smbrs_pkg::ST_ADDR:
                    sda_oe_ff <= byte_done && addr_match;
                smbrs_pkg::ST_RX:
                    sda_oe_ff <= byte_done && rx_accept;
                smbrs_pkg::ST_ADDR_ACK:
                    sda_oe_ff <= rw_ff && !rd_byte[7];
                smbrs_pkg::ST_TX:
                    sda_oe_ff <= !byte_done && !tx_ff[6];
                smbrs_pkg::ST_TX_ACK:
                    sda_oe_ff <= master_ack_ff && !rd_byte[7];
                default:
                    sda_oe_ff <= 1'b0;
            endcase
        end
    end

    // Address pointer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ptr_ff <= '0;
        else if (state_ff == smbrs_pkg::ST_RX && byte_done && ptr_load)
            ptr_ff <= nxt_ptr;
    end

    smbrs_fifo #(
        .W(WR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(push_valid && state_ff == smbrs_pkg::ST_RX && byte_done),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // Writes held back while a page erase runs
    assign drain_ready = !busy_ff;

    // Page erase timer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_ff <= 1'b0;
            erase_cnt_ff <= '0;
            erase_page_ff <= '0;
        end
        else if (busy_ff)
        begin
            erase_cnt_ff <= erase_cnt_ff + 32'h1;
            if (erase_cnt_ff == 32'(ERASE_CYCLES - 1))
                busy_ff <= 1'b0;
        end
        else if (state_ff == smbrs_pkg::ST_RX && byte_done && erase_start)
        begin
            busy_ff <= 1'b1;
            erase_cnt_ff <= '0;
            erase_page_ff <= ptr_ff[9:`SMBRS_PAGE_LSB];
        end
    end

    // Configuration-update register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cfg_ff <= `SMBRS_CFG_RESET;
        else if (drain_valid && drain_ready && !drain_data.to_eep
                 && drain_data.addr[7:0] == `SMBRS_CFG_ADDR)
            cfg_ff <= drain_data.data;
    end

    // RAM array
    always_ff @(posedge clk_sys)
    begin
        if (drain_valid && drain_ready && !drain_data.to_eep)
            ram_mem[drain_data.addr[7:0]] <= drain_data.data;
    end

    // EEPROM array: one byte of the page wiped per cycle at erase start
    always_ff @(posedge clk_sys)
    begin
        if (busy_ff && erase_cnt_ff < 32'(`SMBRS_PAGE_BYTES))
            eep_mem[{erase_page_ff, erase_cnt_ff[4:0]}] <= `SMBRS_EEP_BLANK;
        else if (drain_valid && drain_ready && drain_data.to_eep
                 && eep_mem[drain_data.addr[9:0]] == `SMBRS_EEP_BLANK)
            eep_mem[drain_data.addr[9:0]] <= drain_data.data;
    end

    assign sda_oe = sda_oe_ff;
    assign sda_o = sda_out_ff;
    assign erase_busy = busy_ff;
endmodule

// File: core/smbrs_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module smbrs_sync #(
    parameter int W = 1
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Pins
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // Idle bus level, so no false edge follows reset
            meta_ff <= '1;
            sync_ff <= '1;
        end
        else
        begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule

// File: include/smbrs_cfg.svh
// Constants for the two-wire RAM and EEPROM slave port
`ifndef SMBRS_CFG_SVH
`define SMBRS_CFG_SVH

`define SMBRS_ADDR_UPPER 5'h07
`define SMBRS_RAM_LAST 8'hdf
`define SMBRS_EEP_HI_FIRST 8'hf8
`define SMBRS_EEP_HI_LAST 8'hfb
`define SMBRS_CMD_ERASE 8'hfe
`define SMBRS_CFG_ADDR 8'h90
`define SMBRS_CFG_ERASE_EN_BIT 2
`define SMBRS_CFG_RESET 8'h00
`define SMBRS_EEP_BLANK 8'hff
`define SMBRS_READ_NONE 8'h00
`define SMBRS_RAM_WORDS 224
`define SMBRS_EEP_WORDS 1024
`define SMBRS_PAGE_BYTES 32
`define SMBRS_PAGE_LSB 5
`define SMBRS_FIFO_DEPTH 32
`define SMBRS_BITS_PER_BYTE 4'h8
`define SMBRS_ERASE_TIME_MS 20
`define SMBRS_CLK_HZ 20000000
`define SMBRS_HZ_PER_KHZ 1000

`endif

// File: include/smbrs_pkg.sv
// Types shared by the two-wire RAM and EEPROM slave port
package smbrs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } smbrs_state_t;

    typedef struct packed {
        logic to_eep;
        logic [15:0] addr;
        logic [7:0] data;
    } smbrs_wr_t;

endpackage

// File: verif/smbrs_master_model.sv
// Bus master model driving SCL and pulling SDA low
`timescale 1ns/100ps
module smbrs_master_model (
    // System
    input wire logic clk_sys,
    // Bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter of the 400 ns bus period
    task automatic step();
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic start_c();
        @(posedge clk_sys);
        sda_low <= 1'b1;
        step();
    endtask
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk_sys);
        scl <= 1'b0;
        step();
        sda_low <= ~b;
        step();
        scl <= 1'b1;
        step();
        r = sda;
        @(posedge clk_sys);
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic mack,
        output logic [7:0] rx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], b);
            rx[i] = b;
        end
        bit_io(mack, ack);
    endtask
    task automatic stop_c();
        @(posedge clk_sys);
        scl <= 1'b0;
        step();
        sda_low <= 1'b1;
        step();
        scl <= 1'b1;
        step();
        sda_low <= 1'b0;
        step();
        step();
    endtask
endmodule

// File: verif/smbrs_slave_monitor.sv
// Checker for the two-wire RAM and EEPROM slave port
`timescale 1ns/100ps
module smbrs_slave_monitor #(
    parameter int ERASE_CYCLES = 400000
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Straps and status
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    input wire logic erase_busy
);
    logic sq_ff;
    logic dq_ff;
    logic rw_ff;
    logic [7:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] cmd_ff;
    logic [31:0] bc_ff;
    logic rise;
    logic hit;
    assign rise = scl_i & ~sq_ff;
    assign hit = sh_ff[7:1] == {5'h07, addr_select_hi_pin, addr_select_lo_pin};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Bit count since the last start or stop
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sq_ff <= 1'b1;
            dq_ff <= 1'b1;
            cnt_ff <= 8'h00;
        end
        else
        begin
            sq_ff <= scl_i;
            dq_ff <= sda_i;
            if (scl_i && sq_ff && dq_ff != sda_i)
                cnt_ff <= 8'h00;
            else if (rise)
                cnt_ff <= cnt_ff + 8'h01;
        end
    end
    // Received bits, direction and command byte
    always_ff @(posedge clk_sys)
    begin
        if (rise)
            sh_ff <= {sh_ff[6:0], sda_i};
        if (rise && cnt_ff == 8'h07)
            rw_ff <= sda_i;
        if (rise && cnt_ff == 8'h10)
            cmd_ff <= {sh_ff[6:0], sda_i};
    end
    // Length of the current erase
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            bc_ff <= 32'h0;
        else
            bc_ff <= erase_busy ? bc_ff + 32'h1 : 32'h0;
    end
    property p_stable_high;
        scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe);
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("sda moved, scl high");
    property p_ack_slot;
        $rose(sda_oe) && !rw_ff |-> cnt_ff % 9 == 8;
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("drive outside ack slot");
    property p_addr_own;
        $rose(sda_oe) && cnt_ff == 8'h08 |-> hit && !erase_busy;
    endproperty
    a_addr_own: assert property (p_addr_own) else $error("ack of foreign address");
    property p_ack_match;
        $fell(scl_i) && cnt_ff == 8'h08 && hit && !erase_busy |-> ##[1:5] sda_oe;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("own address not acked");
    property p_nack_ignore;
        $fell(scl_i) && cnt_ff == 8'h08 && !hit |-> !sda_oe [*8];
    endproperty
    a_nack_ignore: assert property (p_nack_ignore) else $error("bus driven on mismatch");
    property p_busy_cause;
        $rose(erase_busy) |-> cmd_ff == 8'hfe && cnt_ff inside {8'h11, 8'h12};
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("erase without command");
    property p_busy_no_ack;
        erase_busy && $past(erase_busy, 2) |-> !$rose(sda_oe);
    endproperty
    a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack during erase");
    property p_busy_max;
        erase_busy |-> bc_ff < ERASE_CYCLES + 1;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("erase too long");
    property p_busy_min;
        $fell(erase_busy) |-> bc_ff >= ERASE_CYCLES;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("erase too short");
    property p_open_drain;
        !sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    c_erase: cover property ($rose(erase_busy));
    c_nack: cover property ($fell(scl_i) && cnt_ff == 8'h08 && !hit);
    c_read: cover property ($fell(scl_i) && rw_ff && cnt_ff == 8'h11);
endmodule

bind smbrs_slave smbrs_slave_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) u_monitor (
    .clk_sys(clk_sys),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .addr_select_hi_pin(addr_select_hi_pin),
    .addr_select_lo_pin(addr_select_lo_pin),
    .erase_busy(erase_busy)
);

// File: verif/smbrs_slave_tb_top.sv
// Self-checking bench for the two-wire RAM and EEPROM slave port
`timescale 1ns/100ps
module smbrs_slave_tb_top;
    logic clk_sys;
    logic rst;
    logic scl;
    logic sda;
    logic m_low;
    logic sda_o;
    logic sda_oe;
    logic hi;
    logic lo;
    logic erase_busy;
    int err_total;
    int samples_checked;
    // Pulled-up wire
    assign sda = ~(sda_oe | m_low);
    smbrs_slave #(.ERASE_CYCLES(400)) uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .addr_select_hi_pin(hi),
        .addr_select_lo_pin(lo),
        .erase_busy(erase_busy)
    );
    smbrs_master_model u_master (
        .clk_sys(clk_sys),
        .sda(sda),
        .scl(scl),
        .sda_low(m_low)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic wrap_up();
        $display("compares %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t bit %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic rw);
        return {5'h07, hi, lo, rw};
    endfunction
    // Address then bytes; the first n_ok of them are acked
    task automatic wr(input logic [7:0] a, input logic [7:0] q[$], input int n_ok);
        logic [7:0] rx;
        logic ack;
        u_master.start_c();
        q.push_front(a);
        foreach (q[i])
        begin
            u_master.byte_io(q[i], 1'b1, rx, ack);
            chk_bit(ack, i >= n_ok);
        end
        u_master.stop_c();
    endtask
    task automatic rd(input logic [7:0] exp);
        logic [7:0] rx;
        logic ack;
        u_master.start_c();
        u_master.byte_io(dev(1'b1), 1'b1, rx, ack);
        chk_bit(ack, 1'b0);
        u_master.byte_io(8'hff, 1'b0, rx, ack);
        chk_byte(rx, exp);
        u_master.byte_io(8'hff, 1'b1, rx, ack);
        chk_byte(rx, exp);
        u_master.stop_c();
    endtask
    task automatic erase(input logic [7:0] lo_b);
        wr(dev(1'b0), '{8'hf9, lo_b}, 3);
        wr(dev(1'b0), '{8'hfe}, 2);
        chk_bit(erase_busy, 1'b1);
        wr(dev(1'b0), '{}, 0);
        for (int n = 0; n < 1000 && erase_busy; n++)
            @(posedge clk_sys);
        chk_bit(erase_busy, 1'b0);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial
    begin
        rst = 1'b1;
        hi = 1'b0;
        lo = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        for (int i = 0; i < 4; i++)
        begin
            {hi, lo} <= 2'(i);
            repeat (4) @(posedge clk_sys);
            wr(dev(1'b0), '{}, 1);
        end
        wr({5'h06, hi, lo, 1'b0}, '{8'h10}, 0);
        wr(dev(1'b0), '{8'h10, 8'ha5}, 3);
        wr(dev(1'b0), '{8'hdf, 8'h3c, 8'h77}, 3);
        wr(dev(1'b0), '{8'h10}, 2);
        rd(8'ha5);
        rd(8'ha5);
        wr(dev(1'b0), '{8'hdf}, 2);
        rd(8'h3c);
        wr(dev(1'b0), '{8'h90, 8'h04}, 3);
        wr(dev(1'b0), '{8'h90}, 2);
        rd(8'h04);
        erase(8'h60);
        wr(dev(1'b0), '{8'hf9, 8'h60, 8'h22}, 4);
        erase(8'h45);
        wr(dev(1'b0), '{8'hf9, 8'h5f, 8'h11}, 4);
        wr(dev(1'b0), '{8'hf9, 8'h45, 8'h5a}, 4);
        wr(dev(1'b0), '{8'hf9, 8'h45, 8'h00}, 4);
        rd(8'h5a);
        wr(dev(1'b0), '{8'h90, 8'h00}, 3);
        wr(dev(1'b0), '{8'hf9, 8'h45}, 3);
        wr(dev(1'b0), '{8'hfe}, 2);
        chk_bit(erase_busy, 1'b0);
        rd(8'h5a);
        wr(dev(1'b0), '{8'h90, 8'h04}, 3);
        erase(8'h45);
        rd(8'hff);
        wr(dev(1'b0), '{8'hf9, 8'h5f}, 3);
        rd(8'hff);
        wr(dev(1'b0), '{8'hf9, 8'h60}, 3);
        rd(8'h22);
        wrap_up();
    end
endmodule
